// [logic/bfa_pkg.sv]
// shared constants of the battery fault alert block
package bfa_pkg;
  // register offsets
  localparam logic [7:0] OFS_PRI = 8'h63;
  localparam logic [7:0] OFS_THM = 8'h64;
  localparam logic [7:0] OFS_OTH = 8'h65;
  localparam logic [7:0] OFS_BAL = 8'h66;
  localparam logic [7:0] OFS_GEN = 8'h67;
  localparam logic [7:0] OFS_OWU = 8'h68;
  localparam logic [7:0] OFS_OWL = 8'h69;
  localparam logic [7:0] OFS_CTL = 8'h6a;
  localparam logic [7:0] OFS_CNT = 8'h6b;
  localparam logic [7:0] OFS_MSK0 = 8'h83;
  localparam int NREG = 7;
  // priority fault bits
  localparam int B_OVC = 0;
  localparam int B_UVC = 1;
  // other fault bits
  localparam int B_PKOV = 7;
  localparam int B_PKUV = 6;
  // balance status and general status bits
  localparam int B_DVC = 3;
  localparam int B_OTHF = 3;
  // control register bits
  localparam int C_PACK = 0;
  localparam int C_CELL = 1;
  localparam int C_AUX = 2;
  localparam int C_DOV = 3;
  localparam int C_CUV = 4;
  localparam int C_CHEN = 5;
  localparam int C_DHEN = 6;
  // filter channel indices
  localparam int F_OV = 0;
  localparam int F_UV = 1;
  localparam int F_DV = 2;
  // reset values
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_MSK = 8'hff;
  localparam logic [3:0] RST_CNT = 4'h1;
  localparam logic [7:0] RD_NONE = 8'h00;
endpackage : bfa_pkg

// [logic/bfa_filt_if.sv]
// carrier between the fault logic and its scan filter
`timescale 1ns/1ps
`default_nettype none
interface bfa_filt_if #(parameter int CNT_W = 4);
  logic scan;
  logic [2:0] det;
  logic [CNT_W-1:0] limit;
  logic [2:0] qual;
  modport src (output scan, output det, output limit, input qual);
  modport filt (input scan, input det, input limit, output qual);
endinterface : bfa_filt_if
`default_nettype wire

// [logic/bfa_scan_filter.sv]
// consecutive-scan qualifier for the cell fault detectors
`timescale 1ns/1ps
`default_nettype none
module bfa_scan_filter #(
  parameter int CNT_W = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  bfa_filt_if.filt f
);
  if (CNT_W < 1) begin : g_chk
    $error("bfa_scan_filter: CNT_W must be at least 1");
  end

  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [CNT_W-1:0] cnt_r;
    logic qual_r;
    // a miss in any scan restarts the run
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        cnt_r <= '0;
      end else if (f.scan) begin
        if (!f.det[i]) begin
          cnt_r <= '0;
        end else if (cnt_r < f.limit) begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
    // limit of zero treated as one scan
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        qual_r <= 1'b0;
      end else if (f.scan) begin
        qual_r <= f.det[i] &&
          ((cnt_r + 1'b1) >= f.limit || cnt_r == f.limit);
      end
    end
    assign f.qual[i] = qual_r;

    AST_MISS_CLEARS: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i) f.scan && !f.det[i] |=> !f.qual[i])
      else $error("qualified flag survived a clean scan");
  end
endmodule : bfa_scan_filter
`default_nettype wire

// [logic/bfa_fault_alert.sv]
// fault flags, alert masking and power switch shutdown
`timescale 1ns/1ps
`default_nettype none
// Operation
// - a mask bit of 0 lets its condition pull the alert output low
// - pack connect setting decides if pack over/undervoltage opens switches
// - cell OV, UV, delta flags set only after programmed consecutive scans
// - with cell connect on, cell OV, UV, delta faults open the switches
// - discharge-during-overvoltage keeps discharge allowed during cell OV
// - charge-during-undervoltage keeps charge allowed during cell UV
// - aux connect setting decides if thermistor faults open the switches
// - host clears by writing 0; flags with live conditions refuse the clear
module bfa_fault_alert import bfa_pkg::*; #(
  parameter int CNT_W = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic scan_done_i,
  input wire logic cell_ov_det_i,
  input wire logic cell_uv_det_i,
  input wire logic cell_dv_det_i,
  input wire logic [7:2] pri_cond_i,
  input wire logic [7:0] thm_cond_i,
  input wire logic [7:0] oth_cond_i,
  input wire logic [7:0] bal_status_i,
  input wire logic [7:0] gen_status_i,
  input wire logic [15:0] open_wire_cond_i,
  output logic fault_alert_output_n_o,
  output logic charge_switch_driver_o,
  output logic discharge_switch_driver_o
);
  if (CNT_W < 1 || CNT_W > 8) begin : g_chk
    $error("bfa_fault_alert: CNT_W must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // scan filter
  // ---------------------------------------------------------------
  bfa_filt_if #(.CNT_W(CNT_W)) filt ();
  logic [CNT_W-1:0] scan_cnt_r;
  assign filt.scan = scan_done_i;
  assign filt.det = {cell_dv_det_i, cell_uv_det_i, cell_ov_det_i};
  assign filt.limit = scan_cnt_r;

  bfa_scan_filter #(.CNT_W(CNT_W)) u_filt (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .f(filt)
  );

  // ---------------------------------------------------------------
  // live conditions per flag register
  // ---------------------------------------------------------------
  logic [7:0] cond [NREG];
  logic [7:0] flag_r [NREG];
  logic [7:0] mask_r [NREG];
  logic [7:0] ctl_r;
  logic [7:0] rd_nxt;
  logic unmasked;

  always_comb begin
    cond[0] = {pri_cond_i, filt.qual[F_UV], filt.qual[F_OV]};
    cond[1] = thm_cond_i;
    cond[2] = oth_cond_i;
    cond[3] = bal_status_i;
    cond[3][B_DVC] = filt.qual[F_DV];
    cond[4] = gen_status_i;
    cond[4][B_OTHF] = |flag_r[1] || |flag_r[2];
    cond[5] = open_wire_cond_i[15:8];
    cond[6] = open_wire_cond_i[7:0];
  end

  // ---------------------------------------------------------------
  // flags: sticky where writable, live where read-only
  // ---------------------------------------------------------------
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    localparam logic [7:0] OFS = OFS_PRI + 8'(r);
    localparam logic [7:0] MOFS = OFS_MSK0 + 8'(r);
    localparam bit RO = (OFS == OFS_BAL) || (OFS == OFS_GEN);
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        flag_r[r] <= 8'h00;
      end else if (RO) begin
        flag_r[r] <= cond[r];
      end else if (reg_wr_i && reg_addr_i == OFS) begin
        // live condition wins over a clearing write
        flag_r[r] <= (flag_r[r] & reg_wdata_i) | cond[r];
      end else begin
        flag_r[r] <= flag_r[r] | cond[r];
      end
    end
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        mask_r[r] <= RST_MSK;
      end else if (reg_wr_i && reg_addr_i == MOFS) begin
        mask_r[r] <= reg_wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctl_r <= RST_CTL;
    end else if (reg_wr_i && reg_addr_i == OFS_CTL) begin
      ctl_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scan_cnt_r <= CNT_W'(RST_CNT);
    end else if (reg_wr_i && reg_addr_i == OFS_CNT) begin
      scan_cnt_r <= reg_wdata_i[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rd_nxt = RD_NONE;
    for (int i = 0; i < NREG; i++) begin
      if (reg_addr_i == OFS_PRI + 8'(i)) begin
        rd_nxt = flag_r[i];
      end
      if (reg_addr_i == OFS_MSK0 + 8'(i)) begin
        rd_nxt = mask_r[i];
      end
    end
    if (reg_addr_i == OFS_CTL) begin
      rd_nxt = ctl_r;
    end
    if (reg_addr_i == OFS_CNT) begin
      rd_nxt = 8'(scan_cnt_r);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= RD_NONE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // alert output
  // ---------------------------------------------------------------
  always_comb begin
    unmasked = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      unmasked = unmasked | (|(flag_r[i] & ~mask_r[i]));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fault_alert_output_n_o <= 1'b1;
    end else begin
      fault_alert_output_n_o <= !unmasked;
    end
  end

  // ---------------------------------------------------------------
  // power switch shutdown
  // ---------------------------------------------------------------
  logic ovc, uvc, dvc, pack_kill, aux_kill;
  logic chg_kill, dchg_kill;
  // latched cell overvoltage and undervoltage flags; delta follows the live balance status bit
  assign ovc = flag_r[0][B_OVC];
  assign uvc = flag_r[0][B_UVC];
  assign dvc = flag_r[3][B_DVC];
  assign pack_kill = ctl_r[C_PACK] &&
    (flag_r[2][B_PKOV] || flag_r[2][B_PKUV]);
  assign aux_kill = ctl_r[C_AUX] && |flag_r[1];
  // exemptions only cover the one fault they name
  assign chg_kill = pack_kill || aux_kill || (ctl_r[C_CELL] &&
    (ovc || dvc || (uvc && !ctl_r[C_CUV])));
  assign dchg_kill = pack_kill || aux_kill || (ctl_r[C_CELL] &&
    (uvc || dvc || (ovc && !ctl_r[C_DOV])));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      charge_switch_driver_o <= 1'b0;
      discharge_switch_driver_o <= 1'b0;
    end else begin
      charge_switch_driver_o <= ctl_r[C_CHEN] && !chg_kill;
      discharge_switch_driver_o <= ctl_r[C_DHEN] && !dchg_kill;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_ALERT_LOW: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) unmasked |=> !fault_alert_output_n_o)
    else $error("unmasked flag did not pull alert low");
  AST_MASK_HIDES: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) !unmasked |=> fault_alert_output_n_o)
    else $error("alert asserted with every flag masked");
  AST_PACK_OFF: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ctl_r[C_PACK] && flag_r[2][B_PKOV]
    |=> !charge_switch_driver_o && !discharge_switch_driver_o)
    else $error("pack fault left a switch on");
  AST_CELL_SET: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) $rose(flag_r[0][B_OVC]) |-> $past(filt.qual[F_OV]))
    else $error("cell overvoltage flag set without qualified run");
  AST_CELL_OFF: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ctl_r[C_CELL] && dvc
    |=> !charge_switch_driver_o && !discharge_switch_driver_o)
    else $error("cell delta fault left a switch on");
  AST_DSC_OV: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ovc && ctl_r[C_DOV] && ctl_r[C_DHEN] &&
    !uvc && !dvc && !pack_kill && !aux_kill |=> discharge_switch_driver_o)
    else $error("discharge blocked despite overvoltage exemption");
  AST_CHG_UV: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) uvc && ctl_r[C_CUV] && ctl_r[C_CHEN] &&
    !ovc && !dvc && !pack_kill && !aux_kill |=> charge_switch_driver_o)
    else $error("charge blocked despite undervoltage exemption");
  AST_AUX_OFF: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ctl_r[C_AUX] && |flag_r[1]
    |=> !charge_switch_driver_o && !discharge_switch_driver_o)
    else $error("thermistor fault left a switch on");
  AST_CLEAR_REFUSED: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) reg_wr_i && reg_addr_i == OFS_PRI &&
    filt.qual[F_OV] |=> flag_r[0][B_OVC])
    else $error("live overvoltage flag was cleared");

  COV_ALERT: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(fault_alert_output_n_o));
  COV_OV_EXEMPT: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    ovc && discharge_switch_driver_o && !charge_switch_driver_o);
  COV_CLEAR: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(flag_r[0][B_OVC]));
endmodule : bfa_fault_alert
`default_nettype wire

// [verification/bfa_host_model.sv]
// host-side register bus model for the fault alert block
`timescale 1ns/1ps
`default_nettype none
module bfa_host_model (
  input wire logic mclk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
  end
  // a flag is cleared by writing 0 to its bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    // idle bus carries no stale value
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    d = reg_rdata_i;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask : rd
endmodule : bfa_host_model
`default_nettype wire

// [verification/battery_fault_alert_logic_bench.sv]
// self-checking bench of the battery fault alert block
`timescale 1ns/1ps
`default_nettype none
module battery_fault_alert_logic_bench;
  import bfa_pkg::*;
  logic mclk_i, rst_n_i, wr, rd, scan, ov, uv, dv, al_n, chg, dis;
  logic [7:0] a, wd, rdat, thm, oth, bal, gen, d;
  logic [7:2] pri;
  logic [15:0] ow, owacc;
  logic [7:0] tbl [4] = '{8'h60, 8'h62, 8'h6a, 8'h00};
  int fails, check_count;
  integer seed;
  bfa_fault_alert #(.CNT_W(4)) u_bfa_fault_alert (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(a),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .scan_done_i(scan),
    .cell_ov_det_i(ov), .cell_uv_det_i(uv), .cell_dv_det_i(dv),
    .pri_cond_i(pri), .thm_cond_i(thm), .oth_cond_i(oth),
    .bal_status_i(bal), .gen_status_i(gen), .open_wire_cond_i(ow),
    .fault_alert_output_n_o(al_n), .charge_switch_driver_o(chg),
    .discharge_switch_driver_o(dis));
  bfa_host_model u_bfa_host_model (.mclk_i(mclk_i), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_addr_o(a), .reg_wdata_o(wd), .reg_rdata_i(rdat));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // f = {ov, uv, delta, pack ov, pack uv, aux}; exemptions cover one fault
  function automatic logic [7:0] xdrv(input logic [7:0] c,
                                      input logic [5:0] f);
    logic cm;
    cm = !(c[C_PACK] && (f[2] || f[1])) && !(c[C_AUX] && f[0]);
    cm = cm && !(c[C_CELL] && f[3]);
    return {6'h00,
      c[C_CHEN] && cm && !(c[C_CELL] && (f[5] || (f[4] && !c[C_CUV]))),
      c[C_DHEN] && cm && !(c[C_CELL] && (f[4] || (f[5] && !c[C_DOV])))};
  endfunction : xdrv
  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  task automatic w(input logic [7:0] ad, input logic [7:0] dt);
    u_bfa_host_model.wr(ad, dt);
  endtask : w
  task automatic r(input logic [7:0] ad, input logic [7:0] e, input string m);
    logic [7:0] g;
    u_bfa_host_model.rd(ad, g);
    chk(g, e, m);
  endtask : r
  task automatic scn(input logic [2:0] v);
    @(negedge mclk_i);
    scan = 1'b1;
    {ov, uv, dv} = v;
    @(negedge mclk_i);
    scan = 1'b0;
    {ov, uv, dv} = ~v;
  endtask : scn
  task automatic drv(input logic [7:0] c, input logic [5:0] f);
    w(OFS_CTL, c);
    cyc(3);
    chk({6'h00, chg, dis}, xdrv(c, f), "drivers");
  endtask : drv
  // hang guard
  initial begin
    #2000000;
    fails++;
    print_verdict();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 32'h3fe5;
    {rst_n_i, scan, ov, uv, dv, pri, thm, oth, bal, gen, ow, owacc} = '0;
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk({7'h00, al_n}, 8'h01, "alert idle");
    r(OFS_MSK0, RST_MSK, "mask rst");
    r(OFS_CTL, RST_CTL, "ctl rst");
    r(OFS_CNT, 8'h01, "cnt rst");
    r(8'h70, RD_NONE, "unmapped");
    w(OFS_BAL, 8'hff);
    r(OFS_BAL, 8'h00, "ro bal");
    $display("test reset done");
    w(OFS_CNT, 8'h03);
    repeat (2) scn(3'b100);
    scn(3'b000);
    repeat (2) scn(3'b100);
    r(OFS_PRI, 8'h00, "ov early");
    scn(3'b100);
    r(OFS_PRI, 8'h01, "ov set");
    w(OFS_MSK0, 8'hfe);
    cyc(3);
    chk({7'h00, al_n}, 8'h00, "alert on");
    w(OFS_MSK0, 8'hff);
    cyc(3);
    chk({7'h00, al_n}, 8'h01, "alert masked");
    r(OFS_PRI, 8'h01, "flag kept");
    foreach (tbl[i]) drv(tbl[i], 6'b100000);
    w(OFS_PRI, 8'h00);
    r(OFS_PRI, 8'h01, "clr refused");
    scn(3'b000);
    w(OFS_PRI, 8'h00);
    r(OFS_PRI, 8'h00, "clr ok");
    pri = 6'h01;
    w(OFS_PRI, 8'h00);
    r(OFS_PRI, 8'h04, "live refused");
    pri = 6'h00;
    w(OFS_PRI, 8'h00);
    r(OFS_PRI, 8'h00, "live clr");
    $display("test flags done");
    repeat (3) scn(3'b010);
    drv(8'h62, 6'b010000);
    drv(8'h72, 6'b010000);
    repeat (3) scn(3'b001);
    r(OFS_BAL, 8'h08, "delta");
    drv(8'h62, 6'b011000);
    scn(3'b000);
    w(OFS_PRI, 8'h00);
    for (int k = 0; k < 3; k++) begin
      oth = (k == 0) ? 8'h80 : (k == 1) ? 8'h40 : 8'h00;
      thm = {7'h00, k == 2};
      drv(8'h60, 6'b000100 >> k);
      drv((k == 2) ? 8'h64 : 8'h61, 6'b000100 >> k);
      oth = 8'h00;
      thm = 8'h00;
      w(OFS_THM, 8'h00);
      w(OFS_OTH, 8'h00);
    end
    $display("test drivers done");
    // a scan count of zero qualifies on the first detecting scan
    w(OFS_CNT, 8'h00);
    scn(3'b100);
    r(OFS_PRI, 8'h01, "cnt zero");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      bal = 8'($random(seed));
      gen = 8'($random(seed));
      ow = 16'($random(seed));
      owacc = owacc | ow;
      w(8'h84, d);
      r(8'h84, d, "mask rw");
      r(OFS_BAL, bal & 8'hf7, "bal live");
      r(OFS_GEN, gen & 8'hf7, "gen live");
      r(OFS_OWU, owacc[15:8], "ow up");
      r(OFS_OWL, owacc[7:0], "ow low");
    end
    $display("test random done");
    print_verdict();
  end
endmodule : battery_fault_alert_logic_bench
`default_nettype wire
